/* rtl/sdfs_pkg.sv */
package sdfs_pkg;

  // Display character codes; values above 9 are the non-digit symbols.
  localparam logic [3:0] DISP_NO_POWER  = 4'h0;
  localparam logic [3:0] DISP_HEALTHY   = 4'h1;
  localparam logic [3:0] DISP_RESOLVER  = 4'h2;
  localparam logic [3:0] DISP_TEMP      = 4'h3;
  localparam logic [3:0] DISP_OVERSPEED = 4'h4;
  localparam logic [3:0] DISP_MAX_CURR  = 4'h6;
  localparam logic [3:0] DISP_RMS_CURR  = 4'h7;
  localparam logic [3:0] DISP_BUS_OV    = 4'h8;
  localparam logic [3:0] DISP_MOTOR_TMP = 4'h9;
  localparam logic [3:0] DISP_DOT_CPU   = 4'hA;
  localparam logic [3:0] DISP_BACKUP_F  = 4'hB;
  localparam logic [3:0] DISP_RECOVERY  = 4'hC;

  // Temperature thresholds in whole degrees Celsius.
  localparam logic [7:0] HS_REDUCE_C  = 8'h55;
  localparam logic [7:0] HS_STOP_C    = 8'h6E;
  localparam logic [7:0] AMBIENT_C    = 8'h3C;

  // Ratios in 1/1024 fixed point: 0.9, 1.15, 1.30.
  localparam logic [11:0] K_RMS_LIMIT = 12'h39A;
  localparam logic [11:0] K_OVERSPEED = 12'h49A;
  localparam logic [11:0] K_MAX_CURR  = 12'h533;
  localparam int          K_SHIFT     = 10;

  // First-order filter shift and brake reduction ratio (0.5).
  localparam int          TAU_SHIFT_DEF = 12;
  localparam logic [11:0] K_BRAKE       = 12'h200;

  // Slow flash half period: 250 ms at 125 MHz.
  localparam int FLASH_MS      = 250;
  localparam int CLK_MHZ       = 125;
  localparam int FLASH_CYCLES  = FLASH_MS * 1000 * CLK_MHZ;

  localparam logic [13:0] MARKS_MAX   = 14'h3FFF;
  localparam logic [15:0] AOUT_RESET  = 16'h0000;

  typedef struct packed {
    logic [15:0] curr_abs;
    logic [15:0] speed_abs;
    logic [7:0]  heatsink_c;
    logic [7:0]  ambient_c;
  } sdfs_meas_s;

  typedef struct packed {
    logic        rms_stop_strategy;
    logic        motor_sensor_en;
    logic        brake_reduce_en;
    logic [15:0] standstill_curr;
    logic [15:0] pulse_curr;
    logic [15:0] max_speed;
  } sdfs_cfg_s;

  typedef enum logic [2:0] {
    SDFS_ST_IDLE  = 3'b001,
    SDFS_ST_RUN   = 3'b010,
    SDFS_ST_FAULT = 3'b100
  } sdfs_state_e;

endpackage : sdfs_pkg

/* rtl/sdfs_supervisor.sv */
`timescale 1ns/1ps
module sdfs_supervisor (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire sdfs_pkg::sdfs_meas_s  meas,
  input  wire sdfs_pkg::sdfs_cfg_s   cfg,
  input  wire logic [15:0]           rms_sample,
  input  wire logic [3:0]            tau_shift,
  input  wire logic                  drift_fault,
  input  wire logic                  resolver_absent,
  input  wire logic                  bus_overvolt,
  input  wire logic                  recovery_fault,
  input  wire logic                  cpu_fault,
  input  wire logic                  backup_fault,
  input  wire logic                  power_present,
  input  wire logic                  online,
  input  wire logic [4:0]            pin_in,
  input  wire logic [4:0]            force_en,
  input  wire logic [4:0]            force_val,
  input  wire logic [1:0]            aout_use_const,
  input  wire logic [15:0]           aout_const0,
  input  wire logic [15:0]           aout_const1,
  input  wire logic [15:0]           aout_var0,
  input  wire logic [15:0]           aout_var1,
  input  wire logic [13:0]           marks_cfg,
  input  wire logic                  marks_load,
  input  wire logic                  zero_teach,
  input  wire logic [15:0]           position,
  output logic                       drive_healthy_out,
  output logic [3:0]                 disp_code,
  output logic                       disp_blank,
  output logic [15:0]                curr_limit,
  output logic                       torque_enable,
  output logic                       fwd_motion_ok,
  output logic                       rev_motion_ok,
  output logic [15:0]                aout0,
  output logic [15:0]                aout1,
  output logic [13:0]                enc_marks,
  output logic [15:0]                enc_zero_pos
);

  // Pin bits: 0 torque release, 1 fwd_rotation_permit, 2 rev_rotation_permit,
  // 3 motor thermal sensor, 4 brake closed.
  logic [4:0]  pin_s1_q;
  logic [4:0]  pin_s2_q;
  logic [4:0]  din;
  logic [31:0] rms_filt_q;
  logic [31:0] rms_filt_d;
  logic [27:0] lim_rms;
  logic [27:0] lim_speed;
  logic [27:0] lim_curr;
  logic [27:0] lim_brake;
  logic        rms_over;
  logic        hs_reduce;
  logic        stop_now;
  logic [3:0]  stop_code;
  logic [3:0]  fault_code_q;
  logic [31:0] flash_cnt_q;
  logic        flash_q;
  logic [15:0] limit_d;
  logic        run_ok;
  sdfs_pkg::sdfs_state_e state_q;

  // Pins come from another domain; two flops keep metastability out of the fault logic.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Forced bits bypass the synchroniser, so an override acts two edges before a pin would.
  assign din = (force_en & force_val) | (~force_en & pin_s2_q);

  // Slow filter tracks the rms sample; a shift stands in for the time constant.
  always_comb begin
    rms_filt_d = rms_filt_q + ({rms_sample, 16'h0000} >> tau_shift)
                 - (rms_filt_q >> tau_shift);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rms_filt_q <= '0;
    end else begin
      rms_filt_q <= rms_filt_d;
    end
  end

  assign rms_over  = rms_filt_q[31:16] > cfg.standstill_curr;
  // Ratios are 1/1024 fixed point; 28-bit products keep every bit before the shift.
  assign lim_rms   = (28'(cfg.standstill_curr) * 28'(sdfs_pkg::K_RMS_LIMIT))
                     >> sdfs_pkg::K_SHIFT;
  assign lim_brake = (28'(cfg.pulse_curr) * 28'(sdfs_pkg::K_BRAKE)) >> sdfs_pkg::K_SHIFT;
  assign lim_speed = (28'(cfg.max_speed) * 28'(sdfs_pkg::K_OVERSPEED)) >> sdfs_pkg::K_SHIFT;
  assign lim_curr  = (28'(cfg.pulse_curr) * 28'(sdfs_pkg::K_MAX_CURR)) >> sdfs_pkg::K_SHIFT;
  assign hs_reduce = meas.heatsink_c >= sdfs_pkg::HS_REDUCE_C;

  // Stop-class detection in display priority order.
  always_comb begin
    stop_now  = 1'b1;
    stop_code = sdfs_pkg::DISP_NO_POWER;
    if (cpu_fault) begin
      stop_code = sdfs_pkg::DISP_DOT_CPU;
    end else if (backup_fault) begin
      stop_code = sdfs_pkg::DISP_BACKUP_F;
    end else if (28'(meas.curr_abs) > lim_curr || drift_fault) begin
      stop_code = sdfs_pkg::DISP_MAX_CURR;
    end else if (meas.heatsink_c >= sdfs_pkg::HS_STOP_C
                 || meas.ambient_c > sdfs_pkg::AMBIENT_C) begin
      stop_code = sdfs_pkg::DISP_TEMP;
    end else if (resolver_absent) begin
      stop_code = sdfs_pkg::DISP_RESOLVER;
    end else if (28'(meas.speed_abs) > lim_speed) begin
      stop_code = sdfs_pkg::DISP_OVERSPEED;
    end else if (bus_overvolt) begin
      stop_code = sdfs_pkg::DISP_BUS_OV;
    end else if (recovery_fault) begin
      stop_code = sdfs_pkg::DISP_RECOVERY;
    end else if (cfg.motor_sensor_en && din[3]) begin
      stop_code = sdfs_pkg::DISP_MOTOR_TMP;
    end else if (rms_over && cfg.rms_stop_strategy) begin
      stop_code = sdfs_pkg::DISP_RMS_CURR;
    end else begin
      stop_now = 1'b0;
    end
  end

  // Only a system reset leaves the fault state.
  // Later faults are ignored once latched, so the first cause stays on show.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q      <= sdfs_pkg::SDFS_ST_IDLE;
      fault_code_q <= sdfs_pkg::DISP_NO_POWER;
    end else begin
      case (state_q)
        sdfs_pkg::SDFS_ST_IDLE, sdfs_pkg::SDFS_ST_RUN: begin
          if (stop_now) begin
            state_q      <= sdfs_pkg::SDFS_ST_FAULT;
            fault_code_q <= stop_code;
          end else if (power_present) begin
            state_q <= sdfs_pkg::SDFS_ST_RUN;
          end else begin
            state_q <= sdfs_pkg::SDFS_ST_IDLE;
          end
        end
        sdfs_pkg::SDFS_ST_FAULT: begin
          state_q <= sdfs_pkg::SDFS_ST_FAULT;
        end
        default: begin
          // An illegal state code is treated as a fault and held until reset.
          state_q <= sdfs_pkg::SDFS_ST_FAULT;
        end
      endcase
    end
  end

  // Free-running phase shared by both blinking codes; far too slow to see in a short run.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 32'(sdfs_pkg::FLASH_CYCLES - 1)) begin
      flash_cnt_q <= '0;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end

  // A stop condition drops the outputs in the cycle it is seen, so a drive that
  // leaves reset with a fault present never pulses healthy high, unless it is the motor sensor pin, which reaches the logic two cycles late,
  // or the rms stop, which waits for the filter to climb over standstill_curr.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_healthy_out <= 1'b0;
    end else if (state_q == sdfs_pkg::SDFS_ST_FAULT || stop_now) begin
      drive_healthy_out <= 1'b0;
    end else begin
      drive_healthy_out <= 1'b1;
    end
  end

  // The rms reduction code wins over the heatsink code when both are active.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      disp_code <= sdfs_pkg::DISP_NO_POWER;
    end else if (state_q == sdfs_pkg::SDFS_ST_FAULT) begin
      disp_code <= fault_code_q;
    end else if (stop_now) begin
      disp_code <= stop_code;
    end else if (rms_over && !cfg.rms_stop_strategy) begin
      disp_code <= sdfs_pkg::DISP_RMS_CURR;
    end else if (hs_reduce) begin
      disp_code <= sdfs_pkg::DISP_TEMP;
    end else if (power_present) begin
      disp_code <= sdfs_pkg::DISP_HEALTHY;
    end else begin
      disp_code <= sdfs_pkg::DISP_NO_POWER;
    end
  end

  // Fault codes stand steady; only the two reduction states blink.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      disp_blank <= 1'b0;
    end else if (state_q == sdfs_pkg::SDFS_ST_FAULT || stop_now) begin
      disp_blank <= 1'b0;
    end else if (rms_over && !cfg.rms_stop_strategy) begin
      disp_blank <= flash_q;
    end else if (hs_reduce) begin
      disp_blank <= flash_q;
    end else begin
      disp_blank <= 1'b0;
    end
  end

  // Current limit: lowest of the rms and brake reductions; the heatsink halves the limit left after the rms step.
  // Halving at the heatsink is a coarse stand-in for a progressive reduction.
  always_comb begin
    limit_d = cfg.pulse_curr;
    if (rms_over && !cfg.rms_stop_strategy && lim_rms[15:0] < limit_d) begin
      limit_d = lim_rms[15:0];
    end
    if (hs_reduce) begin
      limit_d = limit_d >> 1;
    end
    if (cfg.brake_reduce_en && din[4] && lim_brake[15:0] < limit_d) begin
      limit_d = lim_brake[15:0];
    end
  end

  // Current and torque are released only in RUN with no stop condition pending.
  assign run_ok = (state_q == sdfs_pkg::SDFS_ST_RUN) && !stop_now;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      curr_limit    <= '0;
      torque_enable <= 1'b0;
      fwd_motion_ok <= 1'b0;
      rev_motion_ok <= 1'b0;
    end else begin
      curr_limit    <= run_ok ? limit_d : 16'h0000;
      torque_enable <= din[0] && run_ok;
      fwd_motion_ok <= din[1];
      rev_motion_ok <= din[2];
    end
  end

  // Each output picks its source every cycle; scaling to volts lies in the converter.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aout0 <= sdfs_pkg::AOUT_RESET;
      aout1 <= sdfs_pkg::AOUT_RESET;
    end else begin
      aout0 <= aout_use_const[0] ? aout_const0 : aout_var0;
      aout1 <= aout_use_const[1] ? aout_const1 : aout_var1;
    end
  end

  // Marks value is stored as count minus one, so 1..16384 fits 14 bits.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enc_marks    <= sdfs_pkg::MARKS_MAX;
      enc_zero_pos <= '0;
    end else begin
      if (marks_load && !online) begin
        enc_marks <= marks_cfg;
      end
      if (zero_teach && online) begin
        enc_zero_pos <= position;
      end
    end
  end

endmodule : sdfs_supervisor

/* verification/sdfs_chk.sv */
`timescale 1ns/1ps
module sdfs_chk (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire sdfs_pkg::sdfs_meas_s meas,
  input wire sdfs_pkg::sdfs_cfg_s  cfg,
  input wire logic                 resolver_absent,
  input wire logic                 online,
  input wire logic [4:0]           force_en,
  input wire logic [4:0]           force_val,
  input wire logic                 drive_healthy_out,
  input wire logic [3:0]           disp_code,
  input wire logic                 torque_enable,
  input wire logic                 fwd_motion_ok,
  input wire logic                 rev_motion_ok,
  input wire logic [13:0]          enc_marks
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_dropped;
    !drive_healthy_out && !torque_enable;
  endsequence
  sequence s_held;
    (!drive_healthy_out && $stable(disp_code))[*8];
  endsequence
  a_resolver_stop: assert property (resolver_absent |=> s_dropped)
    else $error("resolver stop missed");
  a_fault_latched: assert property ($fell(drive_healthy_out) |=> s_held)
    else $error("stop fault not held");
  a_maxcurr_stop: assert property ((28'(meas.curr_abs) << 10) >
    28'(cfg.pulse_curr) * sdfs_pkg::K_MAX_CURR |=> s_dropped) else $error("max current missed");
  a_heat_stop: assert property (meas.heatsink_c >= sdfs_pkg::HS_STOP_C |=> s_dropped)
    else $error("heatsink stop missed");
  a_ambient_stop: assert property (meas.ambient_c > sdfs_pkg::AMBIENT_C |=> s_dropped)
    else $error("ambient stop missed");
  a_speed_stop: assert property ((28'(meas.speed_abs) << 10) >
    28'(cfg.max_speed) * sdfs_pkg::K_OVERSPEED |=> s_dropped) else $error("overspeed missed");
  a_torque_hold: assert property (force_en[0] && !force_val[0] |=> !torque_enable)
    else $error("torque not held off");
  a_permit_block: assert property (force_en[2:1] == 2'h3 && force_val[2:1] == 2'h0
    |=> !fwd_motion_ok && !rev_motion_ok) else $error("motion not blocked");
  a_marks_frozen: assert property (online |=> $stable(enc_marks))
    else $error("marks changed online");
  a_motor_temp: assert property (cfg.motor_sensor_en && force_en[3] && force_val[3]
    |=> !drive_healthy_out) else $error("motor temperature missed");
endmodule : sdfs_chk
bind sdfs_supervisor sdfs_chk u_chk (.core_clk(core_clk), .rst(rst), .meas(meas), .cfg(cfg),
  .resolver_absent(resolver_absent), .online(online), .force_en(force_en),
  .force_val(force_val), .drive_healthy_out(drive_healthy_out), .disp_code(disp_code),
  .torque_enable(torque_enable), .fwd_motion_ok(fwd_motion_ok),
  .rev_motion_ok(rev_motion_ok), .enc_marks(enc_marks));

/* verification/sdfs_contactor.sv */
`timescale 1ns/1ps
module sdfs_contactor #(
  parameter int CLOSE_CYC = 3
) (
  input  wire logic core_clk,
  input  wire logic drive_healthy_out,
  output logic      power_present
);
  int cnt_q;
  // The coil drops out at once, but the contacts pull in only after a delay.
  always_ff @(posedge core_clk) begin
    if (!drive_healthy_out) begin
      cnt_q         <= 0;
      power_present <= 1'h0;
    end else if (cnt_q == CLOSE_CYC) begin
      power_present <= 1'h1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : sdfs_contactor

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst, online, marks_load, zero_teach, power_present;
  logic healthy, torque, fwd, rev, blank;
  sdfs_pkg::sdfs_meas_s meas;
  sdfs_pkg::sdfs_cfg_s  cfg;
  logic [15:0] rms_sample, position, aout_const0, aout_var1, limit, aout0, aout1, zpos;
  logic [5:0]  flt;
  logic [4:0]  pin_in, force_en, force_val;
  logic [3:0]  tau_shift, disp;
  logic [1:0]  aout_use_const;
  logic [13:0] marks_cfg, marks;
  logic [3:0]  codes [12] = '{4'h6, 4'h2, 4'h8, 4'hC, 4'hA, 4'hB, 4'h6, 4'h3, 4'h3, 4'h4,
                              4'h9, 4'h7};
  int          n_fail = 0;
  int          checks = 0;
  sdfs_supervisor dut (.core_clk(core_clk), .rst(rst), .meas(meas), .cfg(cfg),
    .rms_sample(rms_sample), .tau_shift(tau_shift), .drift_fault(flt[0]),
    .resolver_absent(flt[1]), .bus_overvolt(flt[2]), .recovery_fault(flt[3]),
    .cpu_fault(flt[4]), .backup_fault(flt[5]), .power_present(power_present),
    .online(online), .pin_in(pin_in), .force_en(force_en), .force_val(force_val),
    .aout_use_const(aout_use_const), .aout_const0(aout_const0), .aout_const1(16'h0000),
    .aout_var0(16'h0000), .aout_var1(aout_var1), .marks_cfg(marks_cfg),
    .marks_load(marks_load), .zero_teach(zero_teach), .position(position),
    .drive_healthy_out(healthy), .disp_code(disp), .disp_blank(blank), .curr_limit(limit),
    .torque_enable(torque), .fwd_motion_ok(fwd), .rev_motion_ok(rev), .aout0(aout0),
    .aout1(aout1), .enc_marks(marks), .enc_zero_pos(zpos));
  sdfs_contactor #(.CLOSE_CYC(3)) u_kon (.core_clk(core_clk), .drive_healthy_out(healthy),
    .power_present(power_present));
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic set_defaults;
    meas = '{16'h0000, 16'h0000, 8'h19, 8'h19};
    cfg = '{1'h0, 1'h1, 1'h0, 16'h0400, 16'h07D0, 16'h03E8};
    {rms_sample, tau_shift, flt, pin_in, force_en, force_val} = {20'h0_0001, 21'h00_1C00};
    {online, marks_load, zero_teach, marks_cfg, position} = 33'h0_0000_0000;
    {aout_use_const, aout_const0, aout_var1} = 34'h0_0000_0000;
  endtask : set_defaults
  task automatic do_reset;
    set_defaults();
    rst = 1'h1;
    cyc(10);
    rst = 1'h0;
  endtask : do_reset
  task automatic t_power;
    do_reset();
    chk("marks reset", marks, 16'h3FFF);
    cyc(2);
    chk("code no power", disp, 16'h0000);
    for (int i = 0; i < 20 && power_present !== 1'h1; i++) cyc(1);
    cyc(2);
    chk("code powered", disp, 16'h0001);
    chk("torque on", torque, 16'h0001);
    chk("limit full", limit, 16'h07D0);
  endtask : t_power
  task automatic t_stop(input int k);
    do_reset();
    cyc(8);
    if (k < 6) flt[k] = 1'h1;
    case (k)
      6: meas.curr_abs = 16'h0A29;
      7: meas.heatsink_c = 8'h6E;
      8: meas.ambient_c = 8'h3D;
      9: meas.speed_abs = 16'h047F;
      10: {force_en[3], force_val[3]} = 2'h3;
      11: {cfg.rms_stop_strategy, rms_sample} = {1'h1, 16'h07D0};
      default: ;
    endcase
    for (int i = 0; i < 60 && healthy !== 1'h0; i++) cyc(1);
    cyc(1);
    chk("stop healthy", healthy, 16'h0000);
    chk("stop code", disp, codes[k]);
    chk("stop torque", torque, 16'h0000);
    chk("stop blank", blank, 16'h0000);
    set_defaults();
    cyc(4);
    chk("held code", {healthy, disp}, codes[k]);
  endtask : t_stop
  task automatic t_reduce;
    do_reset();
    cyc(8);
    meas = '{16'h0A20, 16'h047D, 8'h6D, 8'h3C};
    {cfg.motor_sensor_en, pin_in[3]} = 2'h1;
    cyc(6);
    chk("edge values run", healthy, 16'h0001);
    chk("hot code", disp, 16'h0003);
    chk("hot limit", limit, 16'h03E8);
    chk("hot blank", blank, 16'h0000);
    meas.heatsink_c = 8'h19;
    rms_sample = 16'h07D0;
    for (int i = 0; i < 60 && disp !== 4'h7; i++) cyc(1);
    cyc(1);
    chk("rms run", healthy, 16'h0001);
    chk("rms code", disp, 16'h0007);
    chk("rms limit", limit, 16'h039A);
  endtask : t_reduce
  task automatic t_io;
    do_reset();
    cyc(8);
    {marks_load, marks_cfg} = 15'h4010;
    cyc(1);
    {online, marks_load, zero_teach, marks_cfg, position} = {3'h7, 14'h0005, 16'h1234};
    cyc(1);
    {marks_load, zero_teach} = 2'h0;
    cyc(1);
    chk("marks kept", marks, 16'h0010);
    chk("zero taught", zpos, 16'h1234);
    {aout_use_const, aout_const0, aout_var1} = {2'h1, 16'h7FFF, 16'h1111};
    {force_en, force_val, cfg.brake_reduce_en} = {5'h17, 5'h12, 1'h1};
    cyc(2);
    chk("aout0", aout0, 16'h7FFF);
    chk("aout1", aout1, 16'h1111);
    chk("forced pins", {torque, fwd, rev}, 16'h0002);
    force_val = 5'h11;
    cyc(2);
    chk("motion blocked", {torque, fwd, rev}, 16'h0004);
    chk("brake limit", limit, 16'h03E8);
  endtask : t_io
  initial begin
    t_power();
    for (int k = 0; k < 12; k++) t_stop(k);
    t_reduce();
    t_io();
    finish_test();
  end
  // The tests need a few hundred cycles; twenty thousand means a hang.
  initial begin
    #160000;
    n_fail++;
    finish_test();
  end
endmodule : tb_top
